//--- logic/aoc_axis_sub.sv
// Registered subtraction of one axis correction from filtered and unfiltered data.
`timescale 1ns/1ps
module aoc_axis_sub #(
  parameter int ACC_W = aoc_pkg::ACC_W
) (
  input  wire logic                    sys_clk,
  input  wire logic                    rst_n,
  input  wire logic signed [7:0]       corr,
  input  wire logic signed [ACC_W-1:0] rawIn,
  input  wire logic signed [ACC_W-1:0] filtIn,
  output logic signed [ACC_W-1:0]      rawOut,
  output logic signed [ACC_W-1:0]      filtOut
);

  // Correction LSB is 1/128 g; data top byte matches, so shift into position.
  localparam int SHIFT = ACC_W - 8;

  logic signed [ACC_W-1:0] corrScaled;
  logic signed [ACC_W-1:0] rawOut_q, rawOut_d;
  logic signed [ACC_W-1:0] filtOut_q, filtOut_d;

  always_comb begin
    corrScaled = ACC_W'(corr) <<< SHIFT;
    rawOut_d   = rawIn - corrScaled;
    filtOut_d  = filtIn - corrScaled;
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      rawOut_q  <= '0;
      filtOut_q <= '0;
    end else begin
      rawOut_q  <= rawOut_d;
      filtOut_q <= filtOut_d;
    end
  end

  assign rawOut  = rawOut_q;
  assign filtOut = filtOut_q;

endmodule : aoc_axis_sub

//--- logic/aoc_ctrl.sv
// Offset compensation register bank, fast calibration control and data correction.
`timescale 1ns/1ps
// Overview of operation
// - Writing one to zero-all clears the three correction registers.
// - Trigger field 01, 10, 11 starts fast compensation on x, y, z.
// - Done flag reads zero while fast compensation runs, one when idle.
// - Per-axis enable bits switch slow compensation on and off.
// - Target codes select 0 g, +1 g, -1 g, 0 g per axis.
// - Corner bit selects high-pass bandwidth over 1000 or over 100.
// - Each correction is subtracted from filtered and unfiltered axis data.
// - Corrections are two's complement, 1/128 g per step, range independent.
// - Corrections reload from non-volatile memory after power-on or soft reset; here reset clears them to zero and reload waits for an nvmLoad pulse.
// - Host writes corrections; finished fast compensation overwrites that axis.
// - Correction registers are eight-bit read-write, resetting to zero.
// - Z correction register behaves exactly like x and y.
module aoc_ctrl #(
  parameter int ACC_W = aoc_pkg::ACC_W
) (
  input  wire logic                         sys_clk,
  input  wire logic                         rst_n,
  input  wire aoc_pkg::aoc_bus_req_type     busReq,
  output logic [aoc_pkg::DATA_W-1:0]        rdData,
  input  wire logic                         nvmLoad,
  input  wire logic [23:0]                  nvmImage,
  input  wire logic                         sampleValid,
  input  wire aoc_pkg::aoc_axes_type        rawIn,
  input  wire aoc_pkg::aoc_axes_type        filtIn,
  output aoc_pkg::aoc_axes_type             rawOut,
  output aoc_pkg::aoc_axes_type             filtOut,
  output logic [2:0]                        slowEnable,
  output logic [5:0]                        slowTarget,
  output logic                              corner,
  output logic                              fastDone
);

  logic [2:0]        ctrlLow_q, ctrlLow_d;
  logic [6:0]        settings_q, settings_d;
  logic [7:0]        corr_q [3];
  logic [7:0]        corr_d [3];
  logic [7:0]        rdData_q, rdData_d;
  logic              done_q, done_d;
  logic [1:0]        axis_q, axis_d;
  logic              calStart_q, calStart_d;
  logic [1:0]        calTarget;
  logic signed [ACC_W-1:0] calSample;
  logic              calBusy;
  logic              calFinish;
  logic signed [7:0] calCorr;
  logic              ctrlWrite;
  logic [1:0]        trig;
  logic              zeroAll;
  logic [ACC_W-1:0]  rawSel  [3];
  logic [ACC_W-1:0]  filtSel [3];
  logic [ACC_W-1:0]  rawCor  [3];
  logic [ACC_W-1:0]  filtCor [3];

  // The strobe is an argument so that a continuous use re-evaluates when it drops.
  function automatic logic hit(input logic       en,
                               input logic [7:0] a,
                               input logic [7:0] ref_addr);
    hit = en && (a == ref_addr);
  endfunction : hit

  function automatic logic [1:0] axisIndex(input logic [1:0] code);
    axisIndex = code - 2'b01;
  endfunction : axisIndex

  assign ctrlWrite  = hit(busReq.wrEn, busReq.addr, aoc_pkg::ADDR_CONTROL);
  assign trig       = busReq.wrData[aoc_pkg::TRIG_HI:aoc_pkg::TRIG_LO];
  assign zeroAll    = ctrlWrite && busReq.wrData[aoc_pkg::BIT_ZERO_ALL];
  assign rawSel[0]  = rawIn.x;
  assign rawSel[1]  = rawIn.y;
  assign rawSel[2]  = rawIn.z;
  assign filtSel[0] = filtIn.x;
  assign filtSel[1] = filtIn.y;
  assign filtSel[2] = filtIn.z;

  always_comb begin
    // Target fields sit above the corner bit: x at 2:1, y at 4:3, z at 6:5.
    calTarget = settings_q[2*axisIndex(axis_q)+2 -: 2];
    calSample = rawSel[axisIndex(axis_q)];
  end

  always_comb begin
    ctrlLow_d  = ctrlLow_q;
    settings_d = settings_q;
    done_d     = done_q;
    axis_d     = axis_q;
    calStart_d = 1'b0;
    for (int i = 0; i < 3; i++) begin
      corr_d[i] = corr_q[i];
    end
    if (ctrlWrite) begin
      ctrlLow_d = busReq.wrData[2:0] & aoc_pkg::CONTROL_RW_MASK[2:0];
    end
    if (hit(busReq.wrEn, busReq.addr, aoc_pkg::ADDR_SETTINGS)) begin
      settings_d = busReq.wrData[6:0] & aoc_pkg::SETTINGS_RW_MASK[6:0];
    end
    for (int i = 0; i < 3; i++) begin
      if (hit(busReq.wrEn, busReq.addr, aoc_pkg::ADDR_CORR_X + 8'(i))) begin
        corr_d[i] = busReq.wrData;
      end
    end
    // Trigger accepted only when idle; an early trigger is ignored.
    if (ctrlWrite && (trig != aoc_pkg::TRIG_NONE) && done_q) begin
      done_d     = 1'b0;
      axis_d     = trig;
      calStart_d = 1'b1;
    end
    if (calFinish) begin
      corr_d[axisIndex(axis_q)] = calCorr;
      done_d = 1'b1;
    end
    if (zeroAll) begin
      for (int i = 0; i < 3; i++) begin
        corr_d[i] = aoc_pkg::RESET_VALUE;
      end
    end
    if (nvmLoad) begin
      for (int i = 0; i < 3; i++) begin
        corr_d[i] = nvmImage[8*i +: 8];
      end
    end
  end

  always_comb begin
    rdData_d = rdData_q;
    if (busReq.rdEn) begin
      unique case (busReq.addr)
        aoc_pkg::ADDR_CONTROL: rdData_d = {3'b000, done_q, 1'b0, ctrlLow_q};
        aoc_pkg::ADDR_SETTINGS: rdData_d = {1'b0, settings_q};
        aoc_pkg::ADDR_CORR_X: rdData_d = corr_q[0];
        aoc_pkg::ADDR_CORR_Y: rdData_d = corr_q[1];
        aoc_pkg::ADDR_CORR_Z: rdData_d = corr_q[2];
        default: rdData_d = aoc_pkg::RESET_VALUE;
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      ctrlLow_q  <= '0;
      settings_q <= '0;
      rdData_q   <= '0;
      done_q     <= 1'b1;
      axis_q     <= aoc_pkg::TRIG_X;
      calStart_q <= 1'b0;
      for (int i = 0; i < 3; i++) begin
        corr_q[i] <= aoc_pkg::RESET_VALUE;
      end
    end else begin
      ctrlLow_q  <= ctrlLow_d;
      settings_q <= settings_d;
      rdData_q   <= rdData_d;
      done_q     <= done_d;
      axis_q     <= axis_d;
      calStart_q <= calStart_d;
      for (int i = 0; i < 3; i++) begin
        corr_q[i] <= corr_d[i];
      end
    end
  end

  aoc_fast_cal #(
    .ACC_W    (ACC_W),
    .AVG_LOG2 (aoc_pkg::AVG_LOG2)
  ) i_aoc_fast_cal (
    .sys_clk     (sys_clk),
    .rst_n       (rst_n),
    .start       (calStart_q),
    .target      (calTarget),
    .sampleValid (sampleValid),
    .sample      (calSample),
    .busy        (calBusy),
    .finish      (calFinish),
    .corr        (calCorr)
  );

  // Subtraction per axis; index 0 is x, 1 is y, 2 is z.
  for (genvar g = 0; g < 3; g++) begin : g_axis
    aoc_axis_sub #(
      .ACC_W (ACC_W)
    ) i_aoc_axis_sub (
      .sys_clk (sys_clk),
      .rst_n   (rst_n),
      .corr    (corr_q[g]),
      .rawIn   (rawSel[g]),
      .filtIn  (filtSel[g]),
      .rawOut  (rawCor[g]),
      .filtOut (filtCor[g])
    );
  end

  assign rdData     = rdData_q;
  assign slowEnable = ctrlLow_q;
  assign slowTarget = settings_q[6:1];
  assign corner     = settings_q[aoc_pkg::BIT_CORNER];
  assign fastDone   = done_q;
  assign rawOut     = {rawCor[0], rawCor[1], rawCor[2]};
  assign filtOut    = {filtCor[0], filtCor[1], filtCor[2]};

  sequence s_trigger;
    ctrlWrite && (trig != aoc_pkg::TRIG_NONE) && done_q;
  endsequence

  sequence s_cal_started;
    !done_q ##1 calBusy;
  endsequence

  AST_TRIG_CLEARS_DONE: assert property (@(posedge sys_clk) disable iff (!rst_n)
    s_trigger |=> s_cal_started)
    else $error("Done flag not cleared or engine not started after trigger.");

  AST_BUSY_NOT_DONE: assert property (@(posedge sys_clk) disable iff (!rst_n)
    calBusy |-> !done_q)
    else $error("Done flag high while fast compensation runs.");

  AST_FINISH_SETS_DONE: assert property (@(posedge sys_clk) disable iff (!rst_n)
    calFinish && !nvmLoad && !zeroAll
      |=> done_q && corr_q[axisIndex(axis_q)] == $past(calCorr))
    else $error("Finished compensation did not store correction and set done.");

  AST_ZERO_ALL: assert property (@(posedge sys_clk) disable iff (!rst_n)
    zeroAll && !nvmLoad
      |=> corr_q[0] == 8'h00 && corr_q[1] == 8'h00 && corr_q[2] == 8'h00)
    else $error("Zero-all write did not clear corrections.");

  AST_NVM_RELOAD: assert property (@(posedge sys_clk) disable iff (!rst_n)
    nvmLoad |=> {corr_q[2], corr_q[1], corr_q[0]} == $past(nvmImage))
    else $error("Corrections not reloaded from memory image.");

  AST_PULSE_READ_ZERO: assert property (@(posedge sys_clk) disable iff (!rst_n)
    busReq.rdEn && busReq.addr == aoc_pkg::ADDR_CONTROL
      |=> rdData_q[7:5] == 3'b000 && rdData_q[4] == $past(done_q))
    else $error("Control read shows trigger bits or wrong done flag.");

  AST_CTRL_READ_ENABLES: assert property (@(posedge sys_clk) disable iff (!rst_n)
    busReq.rdEn && busReq.addr == aoc_pkg::ADDR_CONTROL
      |=> rdData[2:0] == $past(slowEnable) && rdData[3] == 1'b0)
    else $error("Control read does not show the slow compensation enables.");

  AST_ENABLE_WRITE: assert property (@(posedge sys_clk) disable iff (!rst_n)
    ctrlWrite |=> slowEnable == $past(busReq.wrData[2:0]))
    else $error("Slow compensation enables not taken from write.");

  AST_SETTINGS_WRITE: assert property (@(posedge sys_clk) disable iff (!rst_n)
    hit(busReq.wrEn, busReq.addr, aoc_pkg::ADDR_SETTINGS)
      |=> {slowTarget, corner} == $past(busReq.wrData[6:0]))
    else $error("Settings write not reflected in targets and corner.");

  AST_SETTINGS_READ: assert property (@(posedge sys_clk) disable iff (!rst_n)
    busReq.rdEn && busReq.addr == aoc_pkg::ADDR_SETTINGS
      |=> rdData == {1'b0, $past(slowTarget), $past(corner)})
    else $error("Settings read does not match stored settings.");

  AST_CORR_WRITE_X: assert property (@(posedge sys_clk) disable iff (!rst_n)
    hit(busReq.wrEn, busReq.addr, aoc_pkg::ADDR_CORR_X) && !nvmLoad && !calFinish
      |=> corr_q[0] == $past(busReq.wrData))
    else $error("Host write to x correction not stored.");

  AST_CORR_READ_Y: assert property (@(posedge sys_clk) disable iff (!rst_n)
    busReq.rdEn && busReq.addr == aoc_pkg::ADDR_CORR_Y |=> rdData == $past(corr_q[1]))
    else $error("Y correction read does not match stored value.");

  AST_CORR_HOLD_Z: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !hit(busReq.wrEn, busReq.addr, aoc_pkg::ADDR_CORR_Z) && !calFinish
      && !nvmLoad && !zeroAll |=> $stable(corr_q[2]))
    else $error("Z correction changed without a cause.");

  AST_DONE_HOLDS: assert property (@(posedge sys_clk) disable iff (!rst_n)
    done_q && !(ctrlWrite && trig != aoc_pkg::TRIG_NONE) |=> done_q)
    else $error("Done flag dropped without a trigger.");

  AST_DONE_WAITS: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !done_q && !calFinish |=> !done_q)
    else $error("Done flag rose before compensation finished.");

  AST_START_PULSE: assert property (@(posedge sys_clk) disable iff (!rst_n)
    calStart_q |-> !done_q ##1 !calStart_q)
    else $error("Engine start is not a single-cycle pulse.");

  AST_RDDATA_HOLD: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !busReq.rdEn |=> $stable(rdData))
    else $error("Read data changed without a read.");

  AST_UNMAPPED_READ_ZERO: assert property (@(posedge sys_clk) disable iff (!rst_n)
    busReq.rdEn && (busReq.addr < aoc_pkg::ADDR_CONTROL
      || busReq.addr > aoc_pkg::ADDR_CORR_Z) |=> rdData == 8'h00)
    else $error("Unmapped read did not return zero.");

  AST_SUBTRACT_X: assert property (@(posedge sys_clk) disable iff (!rst_n)
    1'b1 |=> rawOut.x == ACC_W'($past(rawIn.x)
      - (ACC_W'($signed($past(corr_q[0]))) <<< (ACC_W - 8))))
    else $error("X data not corrected by stored value.");

  AST_SUBTRACT_FILT_Z: assert property (@(posedge sys_clk) disable iff (!rst_n)
    1'b1 |=> filtOut.z == ACC_W'($past(filtIn.z)
      - (ACC_W'($signed($past(corr_q[2]))) <<< (ACC_W - 8))))
    else $error("Filtered z data not corrected by stored value.");

  AST_NO_TRIG_IDLE: assert property (@(posedge sys_clk) disable iff (!rst_n)
    ctrlWrite && trig == aoc_pkg::TRIG_NONE && done_q && !calFinish |=> done_q)
    else $error("Zero trigger started compensation.");

endmodule : aoc_ctrl

//--- logic/aoc_fast_cal.sv
// Fast compensation engine: averages one axis and yields its correction value.
`timescale 1ns/1ps
module aoc_fast_cal #(
  parameter int ACC_W    = aoc_pkg::ACC_W,
  parameter int AVG_LOG2 = aoc_pkg::AVG_LOG2
) (
  input  wire logic                    sys_clk,
  input  wire logic                    rst_n,
  input  wire logic                    start,
  input  wire logic [1:0]              target,
  input  wire logic                    sampleValid,
  input  wire logic signed [ACC_W-1:0] sample,
  output logic                         busy,
  output logic                         finish,
  output logic signed [7:0]            corr
);

  typedef enum logic [0:0] {
    IDLE = 1'b0,
    RUN  = 1'b1
  } aoc_cal_state_type;

  localparam int SUM_W = ACC_W + AVG_LOG2;
  localparam logic [AVG_LOG2:0] LAST = (AVG_LOG2+1)'((1 << AVG_LOG2) - 1);

  aoc_cal_state_type    state_q, state_d;
  logic [AVG_LOG2:0]    cnt_q, cnt_d;
  logic signed [SUM_W-1:0] sum_q, sum_d;
  logic                 finish_q, finish_d;
  logic signed [7:0]    corr_q, corr_d;
  logic signed [9:0]    targ;
  logic signed [SUM_W-1:0] total;
  logic signed [SUM_W-1:0] diff;

  // Averaged data is scaled to correction units by taking its top byte.
  always_comb begin
    targ = 10'sd0;
    unique case (target)
      aoc_pkg::TARGET_PLUS1:  targ = aoc_pkg::ONE_G_CORR;
      aoc_pkg::TARGET_MINUS1: targ = -aoc_pkg::ONE_G_CORR;
      default:                targ = 10'sd0;
    endcase
    total = sum_q + SUM_W'(sample);
    diff  = (total >>> (SUM_W - 8)) - SUM_W'(targ);
    state_d  = state_q;
    cnt_d    = cnt_q;
    sum_d    = sum_q;
    finish_d = 1'b0;
    corr_d   = corr_q;
    unique case (state_q)
      IDLE: begin
        if (start) begin
          state_d = RUN;
          cnt_d   = '0;
          sum_d   = '0;
        end
      end
      RUN: begin
        if (sampleValid) begin
          sum_d = total;
          cnt_d = cnt_q + 1'b1;
          if (cnt_q == LAST) begin
            state_d  = IDLE;
            finish_d = 1'b1;
            if (diff > SUM_W'(aoc_pkg::CORR_MAX)) begin
              corr_d = aoc_pkg::CORR_MAX;
            end else if (diff < SUM_W'(aoc_pkg::CORR_MIN)) begin
              corr_d = aoc_pkg::CORR_MIN;
            end else begin
              corr_d = diff[7:0];
            end
          end
        end
      end
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      state_q  <= IDLE;
      cnt_q    <= '0;
      sum_q    <= '0;
      finish_q <= 1'b0;
      corr_q   <= '0;
    end else begin
      state_q  <= state_d;
      cnt_q    <= cnt_d;
      sum_q    <= sum_d;
      finish_q <= finish_d;
      corr_q   <= corr_d;
    end
  end

  assign busy   = (state_q == RUN);
  assign finish = finish_q;
  assign corr   = corr_q;

endmodule : aoc_fast_cal

//--- logic/aoc_pkg.sv
// Package with register map, field layout and types of the offset compensation block.
package aoc_pkg;

  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;
  localparam int ACC_W  = 12;

  localparam logic [7:0] ADDR_CONTROL  = 8'h36;
  localparam logic [7:0] ADDR_SETTINGS = 8'h37;
  localparam logic [7:0] ADDR_CORR_X   = 8'h38;
  localparam logic [7:0] ADDR_CORR_Y   = 8'h39;
  localparam logic [7:0] ADDR_CORR_Z   = 8'h3A;

  localparam int BIT_ZERO_ALL     = 7;
  localparam int TRIG_HI          = 6;
  localparam int TRIG_LO          = 5;
  localparam int BIT_DONE         = 4;
  localparam int BIT_EN_Z         = 2;
  localparam int BIT_EN_Y         = 1;
  localparam int BIT_EN_X         = 0;
  localparam int BIT_CORNER       = 0;

  localparam logic [7:0] CONTROL_RW_MASK  = 8'h07;
  localparam logic [7:0] SETTINGS_RW_MASK = 8'h7F;
  localparam logic [7:0] RESET_VALUE      = 8'h00;

  localparam logic [1:0] TRIG_NONE = 2'b00;
  localparam logic [1:0] TRIG_X    = 2'b01;
  localparam logic [1:0] TRIG_Y    = 2'b10;
  localparam logic [1:0] TRIG_Z    = 2'b11;

  localparam logic [1:0] TARGET_ZERO_A = 2'b00;
  localparam logic [1:0] TARGET_PLUS1  = 2'b01;
  localparam logic [1:0] TARGET_MINUS1 = 2'b10;
  localparam logic [1:0] TARGET_ZERO_B = 2'b11;

  // One g in correction units: -128 is -1 g.
  localparam logic signed [9:0] ONE_G_CORR = 10'sh080;
  localparam logic signed [7:0] CORR_MAX   = 8'sh7F;
  localparam logic signed [7:0] CORR_MIN   = -8'sh80;

  // Averaging depth of fast compensation, as log2 of sample count.
  localparam int AVG_LOG2 = 4;

  typedef struct packed {
    logic              wrEn;
    logic              rdEn;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wrData;
  } aoc_bus_req_type;

  typedef struct packed {
    logic signed [ACC_W-1:0] x;
    logic signed [ACC_W-1:0] y;
    logic signed [ACC_W-1:0] z;
  } aoc_axes_type;

endpackage : aoc_pkg

//--- tb/aoc_ctrl_tb.sv
// Self-checking testbench for the offset compensation register bank.
`timescale 1ns/1ps
module aoc_ctrl_tb;
  localparam int TDRV = 2;

  logic                     sys_clk;
  logic                     rst_n;
  aoc_pkg::aoc_bus_req_type busReq;
  logic [7:0]               rdData;
  logic                     nvmLoad;
  logic [23:0]              nvmImage;
  logic                     sampleValid;
  aoc_pkg::aoc_axes_type    rawIn;
  aoc_pkg::aoc_axes_type    filtIn;
  aoc_pkg::aoc_axes_type    rawOut;
  aoc_pkg::aoc_axes_type    filtOut;
  logic [2:0]               slowEnable;
  logic [5:0]               slowTarget;
  logic                     corner;
  logic                     fastDone;
  int                       badCount;
  int                       totalChecks;
  int                       n;
  logic [5:0]               tgt;
  logic [7:0]               expTab [1:3];

  aoc_ctrl i_aoc_ctrl (
    .sys_clk     (sys_clk),
    .rst_n       (rst_n),
    .busReq      (busReq),
    .rdData      (rdData),
    .nvmLoad     (nvmLoad),
    .nvmImage    (nvmImage),
    .sampleValid (sampleValid),
    .rawIn       (rawIn),
    .filtIn      (filtIn),
    .rawOut      (rawOut),
    .filtOut     (filtOut),
    .slowEnable  (slowEnable),
    .slowTarget  (slowTarget),
    .corner      (corner),
    .fastDone    (fastDone)
  );

  initial begin
    sys_clk = 1'b0;
  end

  always #12.5 sys_clk = ~sys_clk;

  task automatic check(input string what, input logic [35:0] seen, input logic [35:0] expd);
    totalChecks++;
    if (seen !== expd) begin
      badCount++;
      $display("CHECK FAILED %s expected %h seen %h", what, expd, seen);
    end
  endtask : check

  task automatic wrReg(input logic [7:0] addr, input logic [7:0] data);
    @(posedge sys_clk);
    #TDRV;
    busReq.wrEn   = 1'b1;
    busReq.addr   = addr;
    busReq.wrData = data;
    @(posedge sys_clk);
    #TDRV;
    busReq.wrEn = 1'b0;
  endtask : wrReg

  task automatic rdChk(input string what, input logic [7:0] addr, input logic [7:0] expd);
    @(posedge sys_clk);
    #TDRV;
    busReq.rdEn = 1'b1;
    busReq.addr = addr;
    @(posedge sys_clk);
    #TDRV;
    busReq.rdEn = 1'b0;
    check(what, 36'(rdData), 36'(expd));
  endtask : rdChk

  task automatic nvmRestore(input logic [23:0] image);
    @(posedge sys_clk);
    #TDRV;
    nvmLoad  = 1'b1;
    nvmImage = image;
    @(posedge sys_clk);
    #TDRV;
    nvmLoad = 1'b0;
  endtask : nvmRestore

  // Correction in 1/128 g sits four bits up in the 12-bit data word.
  function automatic logic [11:0] expSub(input logic [11:0] d, input logic [7:0] c);
    expSub = d - {c, 4'h0};
  endfunction : expSub

  task automatic testDone;
    $display("Checks made %0d, mismatches %0d", totalChecks, badCount);
    if (badCount == 0 && totalChecks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : testDone

  initial begin
    #500000;
    badCount++;
    testDone();
  end

  initial begin
    rst_n       = 1'b0;
    busReq      = '0;
    nvmLoad     = 1'b0;
    nvmImage    = 24'h00_0000;
    sampleValid = 1'b0;
    rawIn       = '0;
    filtIn      = '0;
    badCount    = 0;
    totalChecks = 0;
    expTab[1]   = 8'h95;
    expTab[2]   = 8'h7F;
    expTab[3]   = 8'h15;
    repeat (10) @(posedge sys_clk);
    #TDRV;
    rst_n = 1'b1;
    check("fastDone after reset", 36'(fastDone), 36'h1);
    rdChk("control reset", aoc_pkg::ADDR_CONTROL, 8'h10);
    for (n = 0; n < 4; n++) rdChk("reset value", 8'h37 + 8'(n), 8'h00);
    rdChk("unmapped read", 8'h35, 8'h00);
    wrReg(aoc_pkg::ADDR_SETTINGS, 8'hFF);
    rdChk("settings reserved bit", aoc_pkg::ADDR_SETTINGS, 8'h7F);
    for (n = 0; n < 4; n++) begin
      tgt = {2'((n + 2) % 4), 2'((n + 1) % 4), 2'(n)};
      wrReg(aoc_pkg::ADDR_SETTINGS, {1'b0, tgt, n[0]});
      check("slowTarget", 36'(slowTarget), 36'(tgt));
      check("corner", 36'(corner), 36'(n[0]));
    end
    for (n = 0; n < 8; n++) begin
      wrReg(aoc_pkg::ADDR_CONTROL, 8'(n) | 8'h08);
      check("slowEnable", 36'(slowEnable), 36'(n));
      rdChk("control enables", aoc_pkg::ADDR_CONTROL, 8'(n) | 8'h10);
    end
    wrReg(aoc_pkg::ADDR_CORR_X, 8'h7F);
    wrReg(aoc_pkg::ADDR_CORR_Y, 8'h80);
    wrReg(aoc_pkg::ADDR_CORR_Z, 8'h01);
    rdChk("corr x", aoc_pkg::ADDR_CORR_X, 8'h7F);
    rdChk("corr y", aoc_pkg::ADDR_CORR_Y, 8'h80);
    rdChk("corr z", aoc_pkg::ADDR_CORR_Z, 8'h01);
    rawIn  = '{x: 12'h064, y: 12'hF9C, z: 12'h005};
    filtIn = '{x: 12'h7FF, y: 12'hF00, z: 12'h123};
    @(posedge sys_clk);
    #TDRV;
    check("rawOut", rawOut, {expSub(12'h064, 8'h7F), expSub(12'hF9C, 8'h80),
                             expSub(12'h005, 8'h01)});
    check("filtOut", filtOut, {expSub(12'h7FF, 8'h7F), expSub(12'hF00, 8'h80),
                               expSub(12'h123, 8'h01)});
    wrReg(aoc_pkg::ADDR_CONTROL, 8'h00);
    rdChk("corr kept", aoc_pkg::ADDR_CORR_X, 8'h7F);
    check("no trigger on 00", 36'(fastDone), 36'h1);
    wrReg(aoc_pkg::ADDR_CONTROL, 8'h85);
    rdChk("pulse bits read zero", aoc_pkg::ADDR_CONTROL, 8'h15);
    for (n = 0; n < 3; n++) rdChk("zero all", 8'h38 + 8'(n), 8'h00);
    nvmRestore(24'h12_3456);
    rdChk("nvm x", aoc_pkg::ADDR_CORR_X, 8'h56);
    rdChk("nvm y", aoc_pkg::ADDR_CORR_Y, 8'h34);
    rdChk("nvm z", aoc_pkg::ADDR_CORR_Z, 8'h12);
    @(posedge sys_clk);
    #TDRV;
    rst_n = 1'b0;
    repeat (2) @(posedge sys_clk);
    #TDRV;
    rst_n = 1'b1;
    rdChk("soft reset clears", aoc_pkg::ADDR_CORR_Z, 8'h00);
    nvmRestore(24'h12_3456);
    rdChk("nvm after reset", aoc_pkg::ADDR_CORR_Z, 8'h12);
    rawIn  = '{x: 12'h150, y: 12'h150, z: 12'h150};
    filtIn = rawIn;
    wrReg(aoc_pkg::ADDR_SETTINGS, 8'h72);
    for (int a = 1; a < 4; a++) begin
      wrReg(aoc_pkg::ADDR_CONTROL, {1'b0, 2'(a), 5'h00});
      check("done low while busy", 36'(fastDone), 36'h0);
      rdChk("control busy", aoc_pkg::ADDR_CONTROL, 8'h00);
      n = 0;
      // The next trigger is written once the flag reports ready or 64 samples have been sent.
      while (fastDone !== 1'b1 && n < 64) begin
        @(posedge sys_clk);
        #TDRV;
        sampleValid = 1'b1;
        @(posedge sys_clk);
        #TDRV;
        sampleValid = 1'b0;
        n++;
      end
      check("done after samples", 36'(fastDone), 36'h1);
      rdChk("fast result", 8'h37 + 8'(a), expTab[a]);
      if (a == 1) begin
        rdChk("other axis kept", aoc_pkg::ADDR_CORR_Y, 8'h34);
      end
    end
    testDone();
  end
endmodule : aoc_ctrl_tb
